// >>> ipvc_interrupt_config.v
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "ipvc_regs.vh"
// Contract
// - Division unit priority comes from bits 15..12 of priority_levels_a.
// - DMA controller priority comes from bits 11..8 of priority_levels_a.
// - Bits 7..4 of priority_levels_a serve watchdog and bus controller.
// - Serial interface priority comes from bits 15..12 of priority_levels_b.
// - Free-running timer priority comes from bits 11..8 of priority_levels_b.
// - Receive-error vector sits in bits 14..8 of vectors_serial_rx.
// - Receive-full vector sits in bits 6..0 of vectors_serial_rx.
// - Transmit-empty vector sits in bits 14..8 of vectors_serial_tx.
// - Transmit-end vector sits in bits 6..0 of vectors_serial_tx.
// - Input-capture vector sits in bits 14..8 of capture/compare register.
// - Output-compare vector sits in bits 6..0 of capture/compare register.
// - Timer overflow vector in bits 14..8; low byte reads zero.
// - Watchdog interval vector sits in bits 14..8 of watchdog/bus register.
// - Bus compare-match vector sits in bits 6..0 of watchdog/bus register.
// - Divider vector is bits 15..0; upper half reads zero.
// - Each DMA channel holds an 8-bit end vector; upper bits zero.
// - Control bit 15 reflects the current NMI pin level, read-only.
// - Control bit 8 picks NMI edge: 0 falling, 1 rising.
// - Vector mode bit: 0 auto vector, 1 external vector.
module ipvc_interrupt_config (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register port
    input wire [31:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata,
    // NMI pin
    input wire nmiPin,
    // Priority levels per source
    output wire [3:0] dividerPriorityField,
    output wire [3:0] dmaPriorityField,
    output wire [3:0] watchdogPriorityField,
    output wire [3:0] busControlPriority,
    output wire [3:0] serialPriorityField,
    output wire [3:0] timerPriorityField,
    // Serial interface vectors
    output wire [6:0] rxErrorVectorField,
    output wire [6:0] rxFullVectorField,
    output wire [6:0] txEmptyVectorField,
    output wire [6:0] txEndVectorField,
    // Free-running timer vectors
    output wire [6:0] captureVectorField,
    output wire [6:0] compareVectorField,
    output wire [6:0] overflowVector,
    // Watchdog and bus controller vectors
    output wire [6:0] intervalVectorField,
    output wire [6:0] busCompareVectorField,
    // Divider and DMA vectors
    output wire [15:0] dividerVector,
    output wire [7:0] dmaEndVector0,
    output wire [7:0] dmaEndVector1,
    // Control outputs
    output wire nmiPinLevel,
    output wire nmiEdgeSelect,
    output wire vectorModeSelect,
    output reg nmiRequest
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [15:0] prioA_r;
    reg [15:0] prioB_r;
    reg [15:0] vecSerRx_r;
    reg [15:0] vecSerTx_r;
    reg [15:0] vecTmrCc_r;
    reg [15:0] vecTmrOvf_r;
    reg [15:0] vecWdtBsc_r;
    reg [15:0] vecDiv_r;
    reg [7:0] vecDma0_r;
    reg [7:0] vecDma1_r;
    reg [15:0] intCtrl_r;
    reg [31:0] rdata_nxt;
    wire nmiLevelSync;
    wire nmiEdge;

    // Mask helper: keep only writable bits, reserved bits stay zero
    function [15:0] masked;
        input [15:0] data;
        input [15:0] mask;
        begin
            masked = data & mask;
        end
    endfunction

    // Address compare helper
    function hit;
        input [31:0] addr;
        input [31:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // ----------------------------------------
    // NMI pin path
    // ----------------------------------------
    // Asynchronous pin: three flops, a change counts when the last two agree
    // A glitch shorter than about two cycles is lost, by design
    ipvc_pin_sync uSync (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(nmiPin),
        .levelOut(nmiLevelSync)
    );

    ipvc_nmi_detect uDetect (
        .clk(clk),
        .rst_n(rst_n),
        .level(nmiLevelSync),
        .riseSel(intCtrl_r[`IPVC_BIT_NMI_EDGE]),
        .nmiPulse(nmiEdge)
    );

    // Registered request pulse, one cycle per detected edge
    always @(posedge clk) begin
        if (!rst_n) begin
            nmiRequest <= 1'b0;
        end else begin
            nmiRequest <= nmiEdge;
        end
    end

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    // One enable per register; an unmapped address raises none of them
    // Decoded once here so each register process stays a plain load
    // Priority registers
    wire wrPrioA = regWr & hit(regAddr, `IPVC_OFS_PRIO_A);
    wire wrPrioB = regWr & hit(regAddr, `IPVC_OFS_PRIO_B);
    // Serial and timer vectors
    wire wrSerRx = regWr & hit(regAddr, `IPVC_OFS_VEC_SER_RX);
    wire wrSerTx = regWr & hit(regAddr, `IPVC_OFS_VEC_SER_TX);
    wire wrTmrCc = regWr & hit(regAddr, `IPVC_OFS_VEC_TMR_CC);
    wire wrTmrOvf = regWr & hit(regAddr, `IPVC_OFS_VEC_TMR_OVF);
    // Watchdog/bus, divider and DMA vectors
    wire wrWdtBsc = regWr & hit(regAddr, `IPVC_OFS_VEC_WDT_BSC);
    wire wrDiv = regWr & hit(regAddr, `IPVC_OFS_VEC_DIV);
    wire wrDma0 = regWr & hit(regAddr, `IPVC_OFS_VEC_DMA0);
    wire wrDma1 = regWr & hit(regAddr, `IPVC_OFS_VEC_DMA1);
    // Control register
    wire wrIntCtrl = regWr & hit(regAddr, `IPVC_OFS_INT_CTRL);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Reserved bits are masked away on entry, so reads need no second mask
    // Upper data bits are ignored; every register sits in the low half

    // Priority levels A: three nibbles, low nibble reserved
    // Watchdog and bus controller share the third nibble
    always @(posedge clk) begin
        if (!rst_n) begin
            prioA_r <= `IPVC_RST_16;
        end else if (wrPrioA) begin
            prioA_r <= masked(regWdata[15:0], `IPVC_MASK_PRIO_A);
        end
    end

    // Priority levels B: two nibbles, low byte reserved
    // Low byte is never stored, so it always reads zero
    always @(posedge clk) begin
        if (!rst_n) begin
            prioB_r <= `IPVC_RST_16;
        end else if (wrPrioB) begin
            prioB_r <= masked(regWdata[15:0], `IPVC_MASK_PRIO_B);
        end
    end

    // Serial receive vectors: error high, data-full low
    always @(posedge clk) begin
        if (!rst_n) begin
            vecSerRx_r <= `IPVC_RST_16;
        end else if (wrSerRx) begin
            vecSerRx_r <= masked(regWdata[15:0], `IPVC_MASK_VEC_PAIR);
        end
    end

    // Serial transmit vectors: data-empty high, end low
    always @(posedge clk) begin
        if (!rst_n) begin
            vecSerTx_r <= `IPVC_RST_16;
        end else if (wrSerTx) begin
            vecSerTx_r <= masked(regWdata[15:0], `IPVC_MASK_VEC_PAIR);
        end
    end

    // Timer capture and compare vectors
    always @(posedge clk) begin
        if (!rst_n) begin
            vecTmrCc_r <= `IPVC_RST_16;
        end else if (wrTmrCc) begin
            vecTmrCc_r <= masked(regWdata[15:0], `IPVC_MASK_VEC_PAIR);
        end
    end

    // Timer overflow vector, high byte only
    // Low byte is read-only zero, so nothing below bit 8 is kept
    always @(posedge clk) begin
        if (!rst_n) begin
            vecTmrOvf_r <= `IPVC_RST_16;
        end else if (wrTmrOvf) begin
            vecTmrOvf_r <= masked(regWdata[15:0], `IPVC_MASK_VEC_HI);
        end
    end

    // Watchdog interval and bus compare-match vectors
    always @(posedge clk) begin
        if (!rst_n) begin
            vecWdtBsc_r <= `IPVC_RST_16;
        end else if (wrWdtBsc) begin
            vecWdtBsc_r <= masked(regWdata[15:0], `IPVC_MASK_VEC_PAIR);
        end
    end

    // Divider vector: the whole low half is writable
    // Its power-up value is not fixed; zero keeps reads defined
    always @(posedge clk) begin
        if (!rst_n) begin
            vecDiv_r <= `IPVC_RST_DIV;
        end else if (wrDiv) begin
            vecDiv_r <= regWdata[15:0];
        end
    end

    // DMA channel 0 end vector
    // Only eight bits are kept; the rest of the word reads zero
    always @(posedge clk) begin
        if (!rst_n) begin
            vecDma0_r <= `IPVC_RST_DMA;
        end else if (wrDma0) begin
            vecDma0_r <= regWdata[7:0];
        end
    end

    // DMA channel 1 end vector
    // Same layout as channel 0, at its own address
    always @(posedge clk) begin
        if (!rst_n) begin
            vecDma1_r <= `IPVC_RST_DMA;
        end else if (wrDma1) begin
            vecDma1_r <= regWdata[7:0];
        end
    end

    // Control: edge select and vector mode only
    // Pin level in bit 15 is never stored; it is read live
    always @(posedge clk) begin
        if (!rst_n) begin
            intCtrl_r <= `IPVC_RST_16;
        end else if (wrIntCtrl) begin
            intCtrl_r <= masked(regWdata[15:0], `IPVC_MASK_INT_CTRL);
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    // Read views: each register as software sees it, narrow ones zero-extended
    wire [31:0] viewPrioA = {16'h0000, prioA_r};
    wire [31:0] viewPrioB = {16'h0000, prioB_r};
    wire [31:0] viewSerRx = {16'h0000, vecSerRx_r};
    wire [31:0] viewSerTx = {16'h0000, vecSerTx_r};
    wire [31:0] viewTmrCc = {16'h0000, vecTmrCc_r};
    wire [31:0] viewTmrOvf = {16'h0000, vecTmrOvf_r};
    wire [31:0] viewWdtBsc = {16'h0000, vecWdtBsc_r};
    // Divider and DMA vectors keep their own widths
    wire [31:0] viewDiv = {16'h0000, vecDiv_r};
    wire [31:0] viewDma0 = {24'h000000, vecDma0_r};
    wire [31:0] viewDma1 = {24'h000000, vecDma1_r};
    // Pin level is live, not stored; stored bit 15 is never set
    wire [31:0] viewIntCtrl = {16'h0000, nmiLevelSync, intCtrl_r[14:0]};

    // Unmapped addresses read as zero; one view per mapped address
    // Exact byte match only, so a stray offset cannot alias a register
    always @* begin
        rdata_nxt = 32'h00000000;
        case (regAddr)
            `IPVC_OFS_PRIO_A: rdata_nxt = viewPrioA;
            `IPVC_OFS_PRIO_B: rdata_nxt = viewPrioB;
            `IPVC_OFS_VEC_SER_RX: rdata_nxt = viewSerRx;
            `IPVC_OFS_VEC_SER_TX: rdata_nxt = viewSerTx;
            `IPVC_OFS_VEC_TMR_CC: rdata_nxt = viewTmrCc;
            `IPVC_OFS_VEC_TMR_OVF: rdata_nxt = viewTmrOvf;
            `IPVC_OFS_VEC_WDT_BSC: rdata_nxt = viewWdtBsc;
            `IPVC_OFS_VEC_DIV: rdata_nxt = viewDiv;
            `IPVC_OFS_VEC_DMA0: rdata_nxt = viewDma0;
            `IPVC_OFS_VEC_DMA1: rdata_nxt = viewDma1;
            `IPVC_OFS_INT_CTRL: rdata_nxt = viewIntCtrl;
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 32'h00000000;
        end else if (regRd) begin
            regRdata <= rdata_nxt;
        end else begin
            regRdata <= 32'h00000000;
        end
    end

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    // Priority levels straight from the stored nibbles
    assign dividerPriorityField = prioA_r[`IPVC_HI_PRIO_MSB -: 4];
    assign dmaPriorityField = prioA_r[`IPVC_MID_PRIO_MSB -: 4];
    // One shared field drives both sources
    assign watchdogPriorityField = prioA_r[`IPVC_LO_PRIO_MSB -: 4];
    assign busControlPriority = prioA_r[`IPVC_LO_PRIO_MSB -: 4];
    assign serialPriorityField = prioB_r[`IPVC_HI_PRIO_MSB -: 4];
    assign timerPriorityField = prioB_r[`IPVC_MID_PRIO_MSB -: 4];

    // Seven-bit vectors, one field per interrupt cause
    assign rxErrorVectorField = vecSerRx_r[`IPVC_HI_VEC_MSB -: 7];
    assign rxFullVectorField = vecSerRx_r[`IPVC_LO_VEC_MSB -: 7];
    assign txEmptyVectorField = vecSerTx_r[`IPVC_HI_VEC_MSB -: 7];
    assign txEndVectorField = vecSerTx_r[`IPVC_LO_VEC_MSB -: 7];
    assign captureVectorField = vecTmrCc_r[`IPVC_HI_VEC_MSB -: 7];
    assign compareVectorField = vecTmrCc_r[`IPVC_LO_VEC_MSB -: 7];
    assign overflowVector = vecTmrOvf_r[`IPVC_HI_VEC_MSB -: 7];
    assign intervalVectorField = vecWdtBsc_r[`IPVC_HI_VEC_MSB -: 7];
    assign busCompareVectorField = vecWdtBsc_r[`IPVC_LO_VEC_MSB -: 7];

    // Divider and DMA vectors pass whole
    assign dividerVector = vecDiv_r;
    assign dmaEndVector0 = vecDma0_r;
    assign dmaEndVector1 = vecDma1_r;

    // Control outputs; pin level trails the pin by the synchroniser delay
    assign nmiPinLevel = nmiLevelSync;
    assign nmiEdgeSelect = intCtrl_r[`IPVC_BIT_NMI_EDGE];
    assign vectorModeSelect = intCtrl_r[`IPVC_BIT_VEC_MODE];
endmodule // ipvc_interrupt_config

// >>> ipvc_interrupt_config_sva.sv
`timescale 1ns/1ps
module ipvc_interrupt_config_sva (
    // Clock and reset
    input logic clk,
    input logic rst_n,
    // Register port
    input logic [31:0] regAddr,
    input logic [31:0] regWdata,
    input logic regWr,
    input logic regRd,
    input logic [31:0] regRdata,
    // Priority levels
    input logic [3:0] dividerPriorityField,
    input logic [3:0] dmaPriorityField,
    input logic [3:0] watchdogPriorityField,
    input logic [3:0] busControlPriority,
    input logic [3:0] serialPriorityField,
    input logic [3:0] timerPriorityField,
    // Vectors
    input logic [6:0] rxErrorVectorField,
    input logic [6:0] rxFullVectorField,
    input logic [6:0] overflowVector,
    input logic [15:0] dividerVector,
    input logic [7:0] dmaEndVector0,
    // Control
    input logic nmiPinLevel,
    input logic nmiEdgeSelect,
    input logic vectorModeSelect,
    input logic nmiRequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // One write cycle to a given byte address
    sequence s_wr(a);
        regWr && regAddr == a;
    endsequence
    a_prio_a_load: assert property (s_wr(32'hFFFFFEE2) |=>
        {dividerPriorityField, dmaPriorityField, watchdogPriorityField, busControlPriority}
        == {$past(regWdata[15:4]), $past(regWdata[7:4])}) else $error("priority A fields wrong");
    a_prio_b_load: assert property (s_wr(32'hFFFFFE60) |=>
        {serialPriorityField, timerPriorityField} == $past(regWdata[15:8]))
        else $error("priority B fields wrong");
    a_rx_vec_load: assert property (s_wr(32'hFFFFFE62) |=>
        {rxErrorVectorField, rxFullVectorField} == {$past(regWdata[14:8]), $past(regWdata[6:0])})
        else $error("serial rx vectors wrong");
    a_ovf_vec_load: assert property (s_wr(32'hFFFFFE68) |=>
        overflowVector == $past(regWdata[14:8])) else $error("overflow vector wrong");
    a_div_vec_load: assert property (s_wr(32'hFFFFFF0C) |=>
        dividerVector == $past(regWdata[15:0])) else $error("divider vector wrong");
    a_dma_vec_load: assert property (s_wr(32'hFFFFFFA0) |=>
        dmaEndVector0 == $past(regWdata[7:0])) else $error("dma vector wrong");
    a_ctrl_load: assert property (s_wr(32'hFFFFFEE0) |=>
        {nmiEdgeSelect, vectorModeSelect} == {$past(regWdata[8]), $past(regWdata[0])})
        else $error("control bits wrong");
    a_rdata_upper_zero: assert property (regRd |=> regRdata[31:16] == 16'h0000)
        else $error("read upper half not zero");
    a_rdata_idle_zero: assert property (!regRd |=> regRdata == 32'h00000000)
        else $error("read data outside read slot");
    a_nmi_one_cycle: assert property (nmiRequest |=> !nmiRequest)
        else $error("nmi request longer than one cycle");
    a_nmi_edge_match: assert property (nmiRequest |-> nmiPinLevel == nmiEdgeSelect)
        else $error("nmi request on unselected edge");
endmodule // ipvc_interrupt_config_sva

bind ipvc_interrupt_config ipvc_interrupt_config_sva i_sva (.clk, .rst_n, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .dividerPriorityField, .dmaPriorityField, .watchdogPriorityField,
    .busControlPriority, .serialPriorityField, .timerPriorityField, .rxErrorVectorField,
    .rxFullVectorField, .overflowVector, .dividerVector, .dmaEndVector0, .nmiPinLevel,
    .nmiEdgeSelect, .vectorModeSelect, .nmiRequest);

// >>> ipvc_interrupt_config_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module ipvc_interrupt_config_tb;
    // ----------------------------------------
    // Signals and register tables
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] regAddr = 32'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic pinWant = 1'b1;
    logic [31:0] regRdata;
    logic [3:0] dividerPriorityField, dmaPriorityField, watchdogPriorityField, busControlPriority;
    logic [3:0] serialPriorityField, timerPriorityField;
    logic [6:0] rxErrorVectorField, rxFullVectorField, txEmptyVectorField, txEndVectorField;
    logic [6:0] captureVectorField, compareVectorField, overflowVector;
    logic [6:0] intervalVectorField, busCompareVectorField;
    logic [15:0] dividerVector;
    logic [7:0] dmaEndVector0, dmaEndVector1;
    logic nmiPin, nmiPinLevel, nmiEdgeSelect, vectorModeSelect, nmiRequest;
    logic [31:0] addrTab [11] = '{32'hFFFFFE60, 32'hFFFFFE62, 32'hFFFFFE64, 32'hFFFFFE66,
        32'hFFFFFE68, 32'hFFFFFEE0, 32'hFFFFFEE2, 32'hFFFFFEE4, 32'hFFFFFF0C, 32'hFFFFFFA0,
        32'hFFFFFFA8};
    // Writable bits per register; everything else reads zero, except the live pin level in control bit 15
    logic [15:0] maskTab [11] = '{16'hFF00, 16'h7F7F, 16'h7F7F, 16'h7F7F, 16'h7F00, 16'h0101,
        16'hFFF0, 16'h7F7F, 16'hFFFF, 16'h00FF, 16'h00FF};
    logic [15:0] sh [11] = '{default: 16'h0000};
    logic [31:0] seed = 32'd87386;
    logic [31:0] r;
    int num_errors = 0;
    int compares = 0;
    int pulses = 0;
    int k;

    ipvc_interrupt_config i_ipvc_interrupt_config (.clk, .rst_n, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .nmiPin, .dividerPriorityField, .dmaPriorityField,
        .watchdogPriorityField, .busControlPriority, .serialPriorityField, .timerPriorityField,
        .rxErrorVectorField, .rxFullVectorField, .txEmptyVectorField, .txEndVectorField,
        .captureVectorField, .compareVectorField, .overflowVector, .intervalVectorField,
        .busCompareVectorField, .dividerVector, .dmaEndVector0, .dmaEndVector1, .nmiPinLevel,
        .nmiEdgeSelect, .vectorModeSelect, .nmiRequest);
    ipvc_nmi_source i_ipvc_nmi_source (.clk(clk), .wantLevel(pinWant), .nmiPin(nmiPin));

    // ----------------------------------------
    // Clock, pulse counter, helpers
    // ----------------------------------------
    always #5 clk = ~clk;
    // Counted every edge, so a stretched pulse shows up as two
    always @(posedge clk) if (nmiRequest === 1'b1) pulses++;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Control register also shows the live pin level in bit 15
    function automatic logic [31:0] expRd(input int i);
        return {16'h0, sh[i]} | ((i == 5) ? {16'h0, pinWant, 15'h0} : 32'h0);
    endfunction
    task wrA(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk) begin regWr <= 1'b1; regAddr <= a; regWdata <= d; end
        @(posedge clk) regWr <= 1'b0;
    endtask
    task wr(input int i, input logic [31:0] d);
        wrA(addrTab[i], d);
        sh[i] = d[15:0] & maskTab[i];
    endtask
    task rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk) begin regRd <= 1'b1; regAddr <= a; end
        @(posedge clk) regRd <= 1'b0;
        #1 `CHK(regRdata, e)
    endtask
    task chkAll;
        for (int i = 0; i < 11; i++) rd(addrTab[i], expRd(i));
        `CHK({dividerPriorityField, dmaPriorityField, watchdogPriorityField, busControlPriority}, {sh[6][15:4], sh[6][7:4]})
        `CHK({serialPriorityField, timerPriorityField}, sh[0][15:8])
        `CHK({rxErrorVectorField, rxFullVectorField}, {sh[1][14:8], sh[1][6:0]})
        `CHK({txEmptyVectorField, txEndVectorField}, {sh[2][14:8], sh[2][6:0]})
        `CHK({captureVectorField, compareVectorField}, {sh[3][14:8], sh[3][6:0]})
        `CHK(overflowVector, sh[4][14:8])
        `CHK({intervalVectorField, busCompareVectorField}, {sh[7][14:8], sh[7][6:0]})
        `CHK(dividerVector, sh[8])
        `CHK({dmaEndVector0, dmaEndVector1}, {sh[9][7:0], sh[10][7:0]})
        `CHK({nmiEdgeSelect, vectorModeSelect}, {sh[5][8], sh[5][0]})
    endtask
    // Move the pin, then count requests over a settled window
    task nmiPhase(input logic lvl, input int n);
        pulses = 0;
        @(posedge clk) pinWant <= lvl;
        repeat (12) @(posedge clk);
        `CHK(pulses, n)
        `CHK(nmiPinLevel, lvl)
    endtask
    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chkAll;
        // Pin held high through reset: release must not look like an edge
        `CHK(pulses, 0)
        wrA(32'hFFFFFE6A, 32'hFFFFFFFF);
        rd(32'hFFFFFE6A, 32'h0);
        for (int i = 0; i < 11; i++) wr(i, 32'hFFFFFFFF);
        chkAll;
        // Random write then immediate readback, reserved bits included
        repeat (40) begin
            k = int'(xs() % 11);
            wr(k, xs());
            rd(addrTab[k], expRd(k));
        end
        chkAll;
        for (int s = 0; s < 2; s++) begin
            r = xs();
            wr(5, {23'h0, s[0], 7'h0, r[0]});
            nmiPhase(!s[0], 0);
            nmiPhase(s[0], 1);
            nmiPhase(!s[0], 0);
            chkAll;
        end
        nmiPhase(1'b1, 1);
        // Second reset in mid-run; pin stays high to avoid a stray request
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        sh = '{default: 16'h0000};
        pulses = 0;
        repeat (6) @(posedge clk);
        chkAll;
        `CHK(pulses, 0)
        end_of_test;
    end
endmodule // ipvc_interrupt_config_tb

// >>> ipvc_nmi_detect.v
`timescale 1ns/1ps
// Edge detector on the synchronised NMI level with selectable polarity
module ipvc_nmi_detect (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Level and edge choice
    input wire level,
    input wire riseSel,
    // Request pulse
    output wire nmiPulse
);
    reg prev_r;

    // ----------------------------------------
    // Previous level
    // ----------------------------------------
    // Seeded at the synchroniser's reset level, so reset alone makes no edge
    always @(posedge clk) begin
        if (!rst_n) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= level;
        end
    end

    // Falling edge when select low, rising when high
    assign nmiPulse = riseSel ? (level & ~prev_r) : (~level & prev_r);
endmodule // ipvc_nmi_detect

// >>> ipvc_nmi_source.sv
`timescale 1ns/1ps
// ----------------------------------------
// NMI pin source
// ----------------------------------------
// Pin moves a few ns after the edge, so the synchroniser sees a true async change
module ipvc_nmi_source (
    // Clock
    input logic clk,
    // Wanted and driven level
    input logic wantLevel,
    output logic nmiPin
);
    // Idle high, so no falling edge is seen around reset
    initial nmiPin = 1'b1;
    always @(posedge clk) begin
        nmiPin <= #3 wantLevel;
    end
endmodule // ipvc_nmi_source

// >>> ipvc_pin_sync.v
`timescale 1ns/1ps
// Three-stage pin synchroniser; output moves when stages two and three agree
module ipvc_pin_sync (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Pin and clean level
    input wire pinIn,
    output reg levelOut
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // ----------------------------------------
    // Shift chain
    // ----------------------------------------
    // First stage feeds only the second, to keep metastability contained
    always @(posedge clk) begin
        if (!rst_n) begin
            // Reset to the pin's idle-high level so release makes no false edge
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            levelOut <= 1'b1;
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                levelOut <= s3_r;
            end
        end
    end
endmodule // ipvc_pin_sync

// >>> ipvc_regs.vh
`ifndef IPVC_REGS_VH
`define IPVC_REGS_VH
// ----------------------------------------
// Register offsets (printed byte addresses)
// ----------------------------------------
`define IPVC_OFS_PRIO_B 32'hFFFFFE60
`define IPVC_OFS_VEC_SER_RX 32'hFFFFFE62
`define IPVC_OFS_VEC_SER_TX 32'hFFFFFE64
`define IPVC_OFS_VEC_TMR_CC 32'hFFFFFE66
`define IPVC_OFS_VEC_TMR_OVF 32'hFFFFFE68
`define IPVC_OFS_INT_CTRL 32'hFFFFFEE0
`define IPVC_OFS_PRIO_A 32'hFFFFFEE2
`define IPVC_OFS_VEC_WDT_BSC 32'hFFFFFEE4
`define IPVC_OFS_VEC_DIV 32'hFFFFFF0C
`define IPVC_OFS_VEC_DMA0 32'hFFFFFFA0
`define IPVC_OFS_VEC_DMA1 32'hFFFFFFA8
// ----------------------------------------
// Field positions
// ----------------------------------------
`define IPVC_HI_PRIO_MSB 15
`define IPVC_MID_PRIO_MSB 11
`define IPVC_LO_PRIO_MSB 7
`define IPVC_HI_VEC_MSB 14
`define IPVC_LO_VEC_MSB 6
`define IPVC_BIT_NMI_LEVEL 15
`define IPVC_BIT_NMI_EDGE 8
`define IPVC_BIT_VEC_MODE 0
// ----------------------------------------
// Write masks and reset values
// ----------------------------------------
`define IPVC_MASK_PRIO_A 16'hFFF0
`define IPVC_MASK_PRIO_B 16'hFF00
`define IPVC_MASK_VEC_PAIR 16'h7F7F
`define IPVC_MASK_VEC_HI 16'h7F00
`define IPVC_MASK_INT_CTRL 16'h0101
`define IPVC_RST_16 16'h0000
`define IPVC_RST_DIV 16'h0000
`define IPVC_RST_DMA 8'h00
`endif
